// ### core/t1dl_core.v
/*
  t1dl_core.v: T1 facility data link logic of one framer: bit-oriented code
  transmit and detect, legacy FDL/Fs byte registers, latched status, masks,
  active-low interrupt, APB register slave.
  Assumes the line framer gives one-cycle strobes at each outgoing FDL/Fs
  slot and each recovered FDL/Fs bit, all synchronous to pclk.
*/
`timescale 1ns/1ps
`include "t1dl_regs.vh"

//Function
//- send-code bit starts and sustains code insertion
//- clearing send-code ends the code sequence after the current word
//- code detection only in T1 ESF
//- detected flag after code persists filter time
//- detected code readable in receive code register
//- detected flag stays clear until new detection
//- cleared flag after code absent disintegration time
//- both code flags can drive masked interrupt
//- FDL source shifts tx byte into FDL/Fs
//- LSB first; empty flag after all bits
//- unrefreshed tx byte is sent again
//- no zero stuffing on tx FDL
//- D4 uses only lower six tx bits
//- rx bits LSB first; full flag, interrupt
//- no zero destuffing on rx FDL
//- D4 rx byte updates per multiframe, Fs only
//- second framer at plus 200 hex
//- code logic works only in T1 ESF mode
module t1dl_core #(
  parameter FRAMER_SEL = 0,
  parameter CODE_BITS = 6,
  parameter FDL_BITS = 8
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire pready,
  output wire pslverr,
  output reg [31:0] prdata,
  // transmit framing side
  input wire tx_slot_stb,
  input wire serial_transmit_input,
  output reg tx_fbit_out,
  // receive framing side
  input wire rx_bit_stb,
  input wire rx_bit,
  input wire rx_mf_stb,
  // interrupt
  output reg interrupt_output_low
);

  reg [7:0] rx_code_control_r;
  reg [7:0] rx_fdl_byte_r;
  reg [7:0] rx_code_value_r;
  reg [2:0] rx_stat_r;
  reg [7:0] rx_interrupt_mask_seven_r;
  reg [7:0] tx_link_control_two_r;
  reg [7:0] tx_fdl_byte_r;
  reg [7:0] tx_code_value_r;
  reg [7:0] tx_control_one_r;
  reg [7:0] tx_control_two_r;
  reg tx_empty_r;
  reg [7:0] tx_interrupt_mask_two_r;
  reg [7:0] framing_mode_r;

  wire [9:0] base_w = (FRAMER_SEL != 0) ? `T1DL_FRAMER_STEP : 10'h000;
  wire [9:0] idx_w = paddr[11:2];

  function hit;
    input [9:0] idx;
    input [9:0] base;
    input [9:0] off;
    begin
      hit = (idx == (base + off));
    end
  endfunction

  wire wr_w = psel & penable & pwrite;
  wire h_rcc = hit(idx_w, base_w, `T1DL_IDX_RX_CODE_CONTROL);
  wire h_rfdl = hit(idx_w, base_w, `T1DL_IDX_RX_FDL_BYTE);
  wire h_rcv = hit(idx_w, base_w, `T1DL_IDX_RX_CODE_VALUE);
  wire h_rls = hit(idx_w, base_w, `T1DL_IDX_RX_LATCHED_STATUS_SEVEN);
  wire h_rim = hit(idx_w, base_w, `T1DL_IDX_RX_INTERRUPT_MASK_SEVEN);
  wire h_tlc = hit(idx_w, base_w, `T1DL_IDX_TX_LINK_CONTROL_TWO);
  wire h_tfdl = hit(idx_w, base_w, `T1DL_IDX_TX_FDL_BYTE);
  wire h_tcv = hit(idx_w, base_w, `T1DL_IDX_TX_CODE_VALUE);
  wire h_tc1 = hit(idx_w, base_w, `T1DL_IDX_TX_CONTROL_ONE);
  wire h_tc2 = hit(idx_w, base_w, `T1DL_IDX_TX_CONTROL_TWO);
  wire h_tls = hit(idx_w, base_w, `T1DL_IDX_TX_LATCHED_STATUS_TWO);
  wire h_tim = hit(idx_w, base_w, `T1DL_IDX_TX_INTERRUPT_MASK_TWO);
  wire h_fm = hit(idx_w, base_w, `T1DL_IDX_FRAMING_MODE);
  // unmapped indices answer with an error, ignore writes and read as zero
  wire mapped_w = h_rcc | h_rfdl | h_rcv | h_rls | h_rim | h_tlc | h_tfdl | h_tcv |
                  h_tc1 | h_tc2 | h_tls | h_tim | h_fm;

  // no wait state: read data is registered during the setup cycle
  assign pready = psel & penable;
  assign pslverr = psel & penable & ~mapped_w;

  wire t1_w = framing_mode_r[`T1DL_BIT_T1_MODE];
  wire esf_w = framing_mode_r[`T1DL_BIT_ESF_MODE];
  wire send_code_control = tx_link_control_two_r[`T1DL_BIT_SEND_CODE];
  wire fbit_pass_through = tx_control_one_r[`T1DL_BIT_FBIT_PASS];
  wire fdl_src_reg_w = ~tx_control_two_r[`T1DL_BIT_FDL_SRC];

  // filter: consecutive identical code words needed before detection
  function [3:0] filt_cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: filt_cnt = 4'h1;
        2'b01: filt_cnt = 4'h3;
        2'b10: filt_cnt = 4'h5;
        default: filt_cnt = 4'h7;
      endcase
    end
  endfunction

  // disintegration: code-word times with no valid word before clearing
  function [3:0] dis_cnt;
    input [1:0] sel;
    begin
      case (sel)
        2'b00: dis_cnt = 4'h1;
        2'b01: dis_cnt = 4'h2;
        2'b10: dis_cnt = 4'h4;
        default: dis_cnt = 4'h8;
      endcase
    end
  endfunction

  // transmit path
  // slot priority: pass-through, then code, then legacy byte, then serial input.
  // a byte cut by a code or pass-through resumes where it stopped, so the
  // empty flag only follows once every bit of the byte has gone out
  reg [3:0] code_pos_r;
  reg [7:0] tx_sr_r;
  reg [2:0] tx_cnt_r;
  // sent from bit 0 up: eight ones, a zero, the six code bits, a zero
  wire [15:0] code_word_w = {1'b0, tx_code_value_r[CODE_BITS-1:0], 1'b0,
                             `T1DL_CODE_FLAG};
  // a started word always runs to its end, so dropping send-code never cuts a word
  wire code_on_w = t1_w & esf_w & (send_code_control | (code_pos_r != 4'h0));
  wire fdl_on_w = ~code_on_w & fdl_src_reg_w;
  // last bit index of a legacy byte: all eight in ESF, the lower six in D4
  localparam [2:0] TX_LAST_ESF = 3'h7;
  localparam [2:0] TX_LAST_D4 = 3'h5;
  wire [2:0] tx_last_w = esf_w ? TX_LAST_ESF : TX_LAST_D4;
  wire tx_done_w = tx_slot_stb & ~fbit_pass_through & fdl_on_w & (tx_cnt_r == tx_last_w);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // the slot bit idles high, as an idle link would
      tx_fbit_out <= 1'b1;
      code_pos_r <= 4'h0;
      tx_sr_r <= 8'h00;
      tx_cnt_r <= 3'd0;
    end else if (tx_slot_stb) begin
      if (fbit_pass_through) begin
        tx_fbit_out <= serial_transmit_input;
      end else if (code_on_w) begin
        tx_fbit_out <= code_word_w[code_pos_r];
        code_pos_r <= code_pos_r + 4'h1;
      end else if (fdl_on_w) begin
        // raw bits, no zero stuffing; reload resends an unrefreshed byte
        if (tx_cnt_r == 3'd0) begin
          tx_fbit_out <= tx_fdl_byte_r[0];
          tx_sr_r <= {1'b0, tx_fdl_byte_r[7:1]};
        end else begin
          tx_fbit_out <= tx_sr_r[0];
          tx_sr_r <= {1'b0, tx_sr_r[7:1]};
        end
        tx_cnt_r <= (tx_cnt_r == tx_last_w) ? 3'd0 : tx_cnt_r + 3'd1;
      end else begin
        tx_fbit_out <= serial_transmit_input;
      end
    end
  end

  // receive code detector
  // the sixteen newest bits sit in rx_sr_r with the oldest at bit 0; a code
  // word is recognised at any alignment, so no word lock is needed.
  // gap_r counts strobes since the last good word; every full sixteen-bit
  // window without a good word counts once toward disintegration.
  // a changed code restarts the filter and, with a filter above one word, drops the valid state quietly,
  // so only a real loss of the code reports the cleared flag
  reg [15:0] rx_sr_r;
  reg [3:0] gap_r;
  reg [3:0] hits_r;
  reg [3:0] miss_r;
  reg [5:0] cand_r;
  reg code_valid_r;
  reg set_bd_r;
  reg set_bc_r;
  wire det_on_w = t1_w & esf_w & rx_bit_stb;
  wire [15:0] rx_next_w = {rx_bit, rx_sr_r[15:1]};
  wire match_w = (rx_next_w[7:0] == `T1DL_CODE_FLAG) & ~rx_next_w[8] & ~rx_next_w[15];
  wire [5:0] rx_code_w = rx_next_w[14:9];
  wire [3:0] need_w = filt_cnt(rx_code_control_r[1:0]);
  wire [3:0] dis_w = dis_cnt(rx_code_control_r[5:4]);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sr_r <= 16'h0000;
      gap_r <= 4'h0;
      hits_r <= 4'h0;
      miss_r <= 4'h0;
      cand_r <= 6'h00;
      code_valid_r <= 1'b0;
      rx_code_value_r <= `T1DL_RST_BYTE;
      set_bd_r <= 1'b0;
      set_bc_r <= 1'b0;
    end else begin
      set_bd_r <= 1'b0;
      set_bc_r <= 1'b0;
      if (det_on_w) begin
        rx_sr_r <= rx_next_w;
        if (match_w) begin
          gap_r <= 4'h0;
          miss_r <= 4'h0;
          if (rx_code_w != cand_r || hits_r == 4'h0) begin
            cand_r <= rx_code_w;
            hits_r <= 4'h1;
            if (need_w == 4'h1 && (!code_valid_r || rx_code_w != cand_r)) begin
              code_valid_r <= 1'b1;
              rx_code_value_r <= {2'b00, rx_code_w};
              set_bd_r <= 1'b1;
            end else if (code_valid_r) begin
              code_valid_r <= 1'b0; // a different code starts a fresh filter
            end
          end else if (hits_r < need_w) begin
            hits_r <= hits_r + 4'h1;
            if (hits_r + 4'h1 == need_w && !code_valid_r) begin
              code_valid_r <= 1'b1;
              rx_code_value_r <= {2'b00, rx_code_w};
              set_bd_r <= 1'b1;
            end
          end
        end else if (gap_r == 4'hf) begin
          gap_r <= 4'h0;
          if (miss_r + 4'h1 >= dis_w) begin
            miss_r <= 4'h0;
            hits_r <= 4'h0;
            if (code_valid_r) begin
              code_valid_r <= 1'b0;
              set_bc_r <= 1'b1;
            end
          end else begin
            miss_r <= miss_r + 4'h1;
          end
        end else begin
          gap_r <= gap_r + 4'h1;
        end
      end
    end
  end

  // receive legacy FDL / Fs byte, raw bits with no destuffing
  // the ESF bit counter free-runs: the host learns that eight more bits
  // arrived, not where any message starts
  reg [7:0] rx_fsr_r;
  reg [2:0] rx_cnt_r;
  reg set_full_r;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_fsr_r <= 8'h00;
      rx_cnt_r <= 3'd0;
      rx_fdl_byte_r <= `T1DL_RST_BYTE;
      set_full_r <= 1'b0;
    end else begin
      set_full_r <= 1'b0;
      if (t1_w && esf_w && rx_bit_stb) begin
        rx_fsr_r <= {rx_bit, rx_fsr_r[7:1]};
        rx_cnt_r <= rx_cnt_r + 3'd1;
        if (rx_cnt_r == FDL_BITS - 1) begin
          rx_fdl_byte_r <= {rx_bit, rx_fsr_r[7:1]};
          set_full_r <= 1'b1;
        end
      end else if (t1_w && !esf_w) begin
        // six Fs bits per multiframe; they land in the upper six shift stages
        // the framer strobes only Fs slots here, never the Ft bits
        if (rx_mf_stb) begin
          rx_fdl_byte_r <= {2'b00, rx_fsr_r[7:2]};
          set_full_r <= 1'b1;
          rx_cnt_r <= 3'd0;
        end else if (rx_bit_stb) begin
          rx_fsr_r <= {rx_bit, rx_fsr_r[7:1]};
        end
      end
    end
  end

  // registers, sticky flags (set wins over a write-one clear)
  // a status write clears only the bits written as one, so the host can
  // acknowledge one flag without losing another that set meanwhile
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_code_control_r <= `T1DL_RST_BYTE;
      rx_interrupt_mask_seven_r <= `T1DL_RST_BYTE;
      tx_link_control_two_r <= `T1DL_RST_BYTE;
      tx_fdl_byte_r <= `T1DL_RST_BYTE;
      tx_code_value_r <= `T1DL_RST_BYTE;
      tx_control_one_r <= `T1DL_RST_BYTE;
      tx_control_two_r <= `T1DL_RST_BYTE;
      tx_interrupt_mask_two_r <= `T1DL_RST_BYTE;
      framing_mode_r <= `T1DL_RST_FRAMING;
      rx_stat_r <= 3'b000;
      tx_empty_r <= 1'b0;
    end else begin
      if (wr_w && h_rcc) rx_code_control_r <= pwdata[7:0];
      if (wr_w && h_rim) rx_interrupt_mask_seven_r <= pwdata[7:0];
      if (wr_w && h_tlc) tx_link_control_two_r <= pwdata[7:0];
      if (wr_w && h_tfdl) tx_fdl_byte_r <= pwdata[7:0];
      if (wr_w && h_tcv) tx_code_value_r <= pwdata[7:0];
      if (wr_w && h_tc1) tx_control_one_r <= pwdata[7:0];
      if (wr_w && h_tc2) tx_control_two_r <= pwdata[7:0];
      if (wr_w && h_tim) tx_interrupt_mask_two_r <= pwdata[7:0];
      if (wr_w && h_fm) framing_mode_r <= pwdata[7:0];
      rx_stat_r <= (rx_stat_r & ~((wr_w && h_rls) ? pwdata[2:0] : 3'b000)) |
                   {set_full_r, set_bc_r, set_bd_r};
      tx_empty_r <= (tx_empty_r & ~(wr_w && h_tls && pwdata[`T1DL_BIT_TX_FDL_EMPTY])) |
                    tx_done_w;
    end
  end

  // interrupt level stays low while any enabled flag is set
  wire rx_irq_w = |(rx_stat_r & rx_interrupt_mask_seven_r[2:0]);
  wire tx_irq_w = tx_empty_r & tx_interrupt_mask_two_r[`T1DL_BIT_TX_FDL_EMPTY];
  // registered so the pin cannot glitch while a flag and its mask change together
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interrupt_output_low <= 1'b1;
    end else begin
      interrupt_output_low <= ~(rx_irq_w | tx_irq_w);
    end
  end

  // read data captured in the setup cycle
  // capturing early gives zero wait states; the value returned is the one
  // standing during the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata <= 32'h00000000;
      if (h_rcc) prdata[7:0] <= rx_code_control_r;
      if (h_rfdl) prdata[7:0] <= rx_fdl_byte_r;
      if (h_rcv) prdata[7:0] <= rx_code_value_r;
      if (h_rls) prdata[7:0] <= {5'b00000, rx_stat_r};
      if (h_rim) prdata[7:0] <= rx_interrupt_mask_seven_r;
      if (h_tlc) prdata[7:0] <= tx_link_control_two_r;
      if (h_tfdl) prdata[7:0] <= tx_fdl_byte_r;
      if (h_tcv) prdata[7:0] <= tx_code_value_r;
      if (h_tc1) prdata[7:0] <= tx_control_one_r;
      if (h_tc2) prdata[7:0] <= tx_control_two_r;
      if (h_tls) prdata[7:0] <= {3'b000, tx_empty_r, 4'h0};
      if (h_tim) prdata[7:0] <= tx_interrupt_mask_two_r;
      if (h_fm) prdata[7:0] <= framing_mode_r;
    end
  end

endmodule

// ### core/t1dl_regs.vh
/*
  t1dl_regs.vh: register indices, field positions, reset values and timing
  figures of the T1 data link block.
  Assumes a word-wide APB slave: byte address = 4 * register index.
*/
`ifndef T1DL_REGS_VH
`define T1DL_REGS_VH

// register indices (byte address is four times the index)
`define T1DL_IDX_RX_CODE_CONTROL 10'h015
`define T1DL_IDX_RX_FDL_BYTE 10'h062
`define T1DL_IDX_RX_CODE_VALUE 10'h063
`define T1DL_IDX_RX_LATCHED_STATUS_SEVEN 10'h096
`define T1DL_IDX_RX_INTERRUPT_MASK_SEVEN 10'h0a6
`define T1DL_IDX_TX_LINK_CONTROL_TWO 10'h113
`define T1DL_IDX_TX_FDL_BYTE 10'h162
`define T1DL_IDX_TX_CODE_VALUE 10'h163
`define T1DL_IDX_TX_CONTROL_ONE 10'h181
`define T1DL_IDX_TX_CONTROL_TWO 10'h182
`define T1DL_IDX_TX_LATCHED_STATUS_TWO 10'h191
`define T1DL_IDX_TX_INTERRUPT_MASK_TWO 10'h1a1
`define T1DL_IDX_FRAMING_MODE 10'h010
// second framer copy sits this many indices higher
`define T1DL_FRAMER_STEP 10'h200

// field positions
`define T1DL_BIT_SEND_CODE 6
`define T1DL_BIT_FBIT_PASS 6
`define T1DL_BIT_FDL_SRC 7
`define T1DL_BIT_CODE_DETECTED 0
`define T1DL_BIT_CODE_CLEARED 1
`define T1DL_BIT_RX_FDL_FULL 2
`define T1DL_BIT_TX_FDL_EMPTY 4
`define T1DL_BIT_T1_MODE 0
`define T1DL_BIT_ESF_MODE 1

// reset values
`define T1DL_RST_BYTE 8'h00
`define T1DL_RST_FRAMING 8'h03

// bit-oriented code word: eight ones, zero, six code bits, zero
`define T1DL_CODE_FLAG 8'hff

// host service window for the legacy FDL bytes
`define T1DL_HOST_WINDOW_NS 2000000
`define T1DL_CLK_NS 8
`define T1DL_HOST_WINDOW_CYC (`T1DL_HOST_WINDOW_NS / `T1DL_CLK_NS)

`endif

// ### verification/t1dl_core_asserts.sv
/*
  t1dl_core_asserts.sv: port checker of t1dl_core.
  Assumes it is bound to the core and sees only its ports.
*/
`timescale 1ns/1ps
module t1dl_core_asserts #(
  parameter FRAMER_SEL = 0
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire pready,
  input wire pslverr,
  input wire [31:0] prdata,
  // line side and interrupt
  input wire tx_slot_stb,
  input wire serial_transmit_input,
  input wire tx_fbit_out,
  input wire rx_bit_stb,
  input wire rx_bit,
  input wire rx_mf_stb,
  input wire interrupt_output_low
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire [9:0] idx = paddr[11:2] - ((FRAMER_SEL != 0) ? 10'h200 : 10'h000);
  wire mapped = idx inside {10'h010, 10'h015, 10'h062, 10'h063, 10'h096, 10'h0a6,
    10'h113, 10'h162, 10'h163, 10'h181, 10'h182, 10'h191, 10'h1a1};
  // the interrupt may only move a few cycles after a strobe or a write
  logic [2:0] since_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      since_r <= 3'h7;
    end else if (tx_slot_stb || rx_bit_stb || rx_mf_stb || (acc && pwrite)) begin
      since_r <= 3'h0;
    end else if (since_r != 3'h7) begin
      since_r <= since_r + 3'h1;
    end
  end
  ready_in_access_a: assert property (pready == acc)
    else $error("pready outside access phase");
  unmapped_error_a: assert property (pslverr == (acc && !mapped))
    else $error("pslverr wrong for index");
  rdata_upper_a: assert property (acc |-> prdata[31:8] == 24'h000000)
    else $error("prdata upper bits set");
  rdata_stands_a: assert property (acc |=> $stable(prdata))
    else $error("prdata moved after access");
  fbit_holds_a: assert property (!$past(tx_slot_stb) |-> $stable(tx_fbit_out))
    else $error("tx bit moved without slot");
  irq_fall_cause_a: assert property ($fell(interrupt_output_low) |-> since_r < 3'h5)
    else $error("interrupt asserted without event");
  irq_rise_write_a: assert property ($rose(interrupt_output_low) |-> $past(acc && pwrite, 2))
    else $error("interrupt released without write");
  irq_quiet_a: assert property (since_r == 3'h7 |-> $stable(interrupt_output_low))
    else $error("interrupt moved while idle");
  cover property ($fell(interrupt_output_low));
  cover property (acc && pslverr);
  cover property (rx_mf_stb);
endmodule
bind t1dl_core t1dl_core_asserts #(.FRAMER_SEL(FRAMER_SEL)) chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata, .tx_slot_stb,
  .serial_transmit_input, .tx_fbit_out, .rx_bit_stb, .rx_bit, .rx_mf_stb,
  .interrupt_output_low);

// ### verification/t1dl_core_test.sv
/*
  t1dl_core_test.sv: self-checking bench of t1dl_core.
  Assumes the line model drives the framing side; APB is driven here.
*/
`timescale 1ns/1ps
`include "t1dl_regs.vh"
module t1dl_core_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  wire pready, pslverr, tx_slot_stb, serial_transmit_input, tx_fbit_out;
  wire rx_bit_stb, rx_bit, rx_mf_stb, interrupt_output_low;
  wire [31:0] prdata;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rd_v;
  logic err_v;
  logic [15:0] got, ser, w;
  logic [7:0] b;
  logic [5:0] c;
`define RS `T1DL_IDX_RX_LATCHED_STATUS_SEVEN
`define TS `T1DL_IDX_TX_LATCHED_STATUS_TWO
`define FM `T1DL_IDX_FRAMING_MODE
`define CHK(a, e) begin \
  checked++; \
  if ((a) !== (e)) begin \
    n_fail++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
  end \
end
  always #4 pclk = ~pclk;
  t1dl_core #(.FRAMER_SEL(0)) uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .pslverr, .prdata, .tx_slot_stb, .serial_transmit_input,
    .tx_fbit_out, .rx_bit_stb, .rx_bit, .rx_mf_stb, .interrupt_output_low);
  t1dl_line_model line (.pclk, .tx_fbit_out, .tx_slot_stb, .serial_transmit_input,
    .rx_bit_stb, .rx_bit, .rx_mf_stb);
  task automatic apb(input logic wr1, input logic [9:0] i, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr1;
    paddr <= {i, 2'b00};
    pwdata <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the watchdog ends a wait that never sees pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [9:0] i, input logic [7:0] d);
    apb(1'b1, i, d);
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    apb(1'b0, i, 8'h00);
    `CHK(rd_v, ({24'h000000, e}))
  endtask
  task summarize;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
  initial begin
    void'($urandom(32'h39ccd8ee));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FM, 8'h03);
    rd(`RS, 8'h00);
    wr(`T1DL_IDX_RX_FDL_BYTE, 8'hff);
    rd(`T1DL_IDX_RX_FDL_BYTE, 8'h00);
    apb(1'b0, `T1DL_IDX_TX_FDL_BYTE + `T1DL_FRAMER_STEP, 8'h00);
    `CHK(err_v, 1'b1)
    wr(`T1DL_IDX_TX_INTERRUPT_MASK_TWO, 8'h10);
    for (int r = 0; r < 4; r++) begin
      if (r == 0) b = 8'hff;
      if (r == 2) b = 8'($urandom);
      if (!r[0]) wr(`T1DL_IDX_TX_FDL_BYTE, b);
      line.slots(8, got, ser);
      `CHK(got[7:0], b)
      `CHK(interrupt_output_low, 1'b0)
      rd(`TS, 8'h10);
      wr(`TS, 8'h10);
      rd(`TS, 8'h00);
      `CHK(interrupt_output_low, 1'b1)
    end
    wr(`FM, 8'h01);
    wr(`T1DL_IDX_TX_FDL_BYTE, 8'h1c);
    line.slots(6, got, ser);
    `CHK(got[5:0], 6'h1c)
    rd(`TS, 8'h10);
    wr(`T1DL_IDX_TX_INTERRUPT_MASK_TWO, 8'h00);
    wr(`FM, 8'h03);
    c = 6'($urandom);
    w = {1'b0, c, 1'b0, 8'hff};
    wr(`T1DL_IDX_TX_CODE_VALUE, {2'b11, c});
    wr(`T1DL_IDX_TX_LINK_CONTROL_TWO, 8'h40);
    line.slots(16, got, ser);
    `CHK(got, w)
    line.slots(4, got, ser);
    wr(`T1DL_IDX_TX_LINK_CONTROL_TWO, 8'h00);
    line.slots(12, got, ser);
    `CHK(got[11:0], w[15:4])
    wr(`T1DL_IDX_TX_CONTROL_ONE, 8'h40);
    line.slots(8, got, ser);
    `CHK(got[7:0], ser[7:0])
    wr(`T1DL_IDX_TX_CONTROL_ONE, 8'h00);
    // legacy byte not selected: serial input passes and no empty flag rises
    wr(`T1DL_IDX_TX_CONTROL_TWO, 8'h80);
    wr(`TS, 8'h10);
    line.slots(8, got, ser);
    `CHK(got[7:0], ser[7:0])
    rd(`TS, 8'h00);
    wr(`T1DL_IDX_TX_CONTROL_TWO, 8'h00);
    wr(`T1DL_IDX_RX_INTERRUPT_MASK_SEVEN, 8'h04);
    b = 8'($urandom);
    line.rxs({8'h00, b}, 8, 1'b0);
    rd(`T1DL_IDX_RX_FDL_BYTE, b);
    `CHK(interrupt_output_low, 1'b0)
    rd(`RS, 8'h04);
    wr(`FM, 8'h01);
    b = 8'($urandom);
    line.rxs({8'h00, b}, 6, 1'b1);
    rd(`T1DL_IDX_RX_FDL_BYTE, {2'b00, b[5:0]});
    wr(`FM, 8'h03);
    wr(`T1DL_IDX_RX_CODE_CONTROL, 8'h00);
    wr(`T1DL_IDX_RX_INTERRUPT_MASK_SEVEN, 8'h03);
    wr(`RS, 8'h07);
    c = 6'($urandom);
    w = {1'b0, c, 1'b0, 8'hff};
    repeat (2) line.rxs(w, 16, 1'b0);
    rd(`T1DL_IDX_RX_CODE_VALUE, {2'b00, c});
    apb(1'b0, `RS, 8'h00);
    `CHK(rd_v[1:0], 2'b01)
    `CHK(interrupt_output_low, 1'b0)
    wr(`RS, 8'h01);
    line.rxs(w, 16, 1'b0);
    apb(1'b0, `RS, 8'h00);
    `CHK(rd_v[0], 1'b0)
    repeat (3) line.rxs(16'h0000, 16, 1'b0);
    apb(1'b0, `RS, 8'h00);
    `CHK(rd_v[1], 1'b1)
    for (int m = 1; m < 3; m++) begin
      wr(`FM, 8'(m));
      wr(`RS, 8'h07);
      repeat (2) line.rxs(w, 16, 1'b0);
      apb(1'b0, `RS, 8'h00);
      `CHK(rd_v[0], 1'b0)
    end
    // filter of three words, two empty windows: detect after word 3, clear after 5
    wr(`FM, 8'h03);
    wr(`T1DL_IDX_RX_CODE_CONTROL, 8'h11);
    wr(`RS, 8'h07);
    for (int n = 0; n < 5; n++) begin
      line.rxs((n < 3) ? w : 16'h0000, 16, 1'b0);
      apb(1'b0, `RS, 8'h00);
      `CHK(rd_v[1:0], ({n > 3, n > 1}))
    end
    summarize();
  end
endmodule

// ### verification/t1dl_line_model.sv
/*
  t1dl_line_model.sv: line framing model, gives FDL/Fs slot strobes and
  recovered bits. Assumes the bench calls its tasks from one process.
*/
`timescale 1ns/1ps
module t1dl_line_model (
  // clock and transmit bit
  input wire pclk,
  input wire tx_fbit_out,
  // toward the framer
  output logic tx_slot_stb = 1'b0,
  output logic serial_transmit_input = 1'b0,
  output logic rx_bit_stb = 1'b0,
  output logic rx_bit = 1'b0,
  output logic rx_mf_stb = 1'b0
);
  task automatic slots(input int n, output logic [15:0] got, output logic [15:0] ser);
    got = 16'h0000;
    ser = 16'h0000;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      tx_slot_stb <= 1'b1;
      ser[i] = 1'($urandom);
      serial_transmit_input <= ser[i];
      @(posedge pclk);
      tx_slot_stb <= 1'b0;
      // hold time over: show the inverse, not the last value
      serial_transmit_input <= ~ser[i];
      @(posedge pclk);
      got[i] = tx_fbit_out;
    end
    repeat (3) @(posedge pclk);
  endtask
  task automatic rxs(input logic [15:0] d, input int n, input logic mf);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      rx_bit_stb <= 1'b1;
      rx_bit <= d[i];
      @(posedge pclk);
      rx_bit_stb <= 1'b0;
      rx_bit <= ~d[i];
    end
    if (mf) begin
      @(posedge pclk);
      rx_mf_stb <= 1'b1;
      @(posedge pclk);
      rx_mf_stb <= 1'b0;
    end
    repeat (4) @(posedge pclk);
  endtask
endmodule
